// ==== inc/sqx_map.vh ====
`ifndef SQX_MAP_VH
`define SQX_MAP_VH

// ==========================================================================
// Opcode fields and fixed patterns
// ==========================================================================
`define SQX_OP_HI          23:20
`define SQX_SQA_HI_VAL     4'hF
`define SQX_SQA_FIX_LO     1'b1
`define SQX_SQA_TAIL_VAL   2'h2
`define SQX_SWAP_HI_VAL    12'hFD0
`define SQX_SCAN_HI_VAL    12'hDF0
`define SQX_SCAN_MODE_MAX  3'h5
`define SQX_WORD_STEP      16'h0002

// ==========================================================================
// Fixed working register numbers
// ==========================================================================
`define SQX_SQ_BASE        4'h4
`define SQX_XPTR_BASE      4'h8
`define SQX_YPTR_BASE      4'hA
`define SQX_OFFSET_REG     4'hC

// ==========================================================================
// Status word bit positions and reset values of status, working registers and accumulators
// ==========================================================================
`define SQX_STAT_CARRY     0
`define SQX_STAT_ANY_SAT   10
`define SQX_STAT_ANY_OVF   11
`define SQX_STAT_B_SAT     12
`define SQX_STAT_A_SAT     13
`define SQX_STAT_B_OVF     14
`define SQX_STAT_A_OVF     15
`define SQX_STAT_RESET     16'h0000
`define SQX_WREG_RESET     16'h0000
`define SQX_ACC_RESET      40'h00_0000_0000

// ==========================================================================
// APB register word indexes (byte address is four times the index)
// ==========================================================================
`define SQX_IDX_WREG_LAST  6'h0F
`define SQX_IDX_ACC_A_LO   6'h10
`define SQX_IDX_ACC_A_HI   6'h11
`define SQX_IDX_ACC_B_LO   6'h12
`define SQX_IDX_ACC_B_HI   6'h13
`define SQX_IDX_STATUS     6'h14

`endif

// ==== core/sqx_exec.v ====
`timescale 1ns/100ps
`include "sqx_map.vh"

module sqx_exec
(
  // Clock and reset.
  input  wire        CLK_I,
  input  wire        NRST_I,
  // Instruction from the decoder.
  input  wire [23:0] INSN_I,
  input  wire        INSN_VALID_I,
  output reg         BUSY_O,
  output reg         EXEC_DONE_O,
  output reg         PASS_O,
  // Data memory prefetch ports.
  output reg         MEM_X_REQ_O,
  output reg  [15:0] MEM_X_ADDR_O,
  output reg         MEM_Y_REQ_O,
  output reg  [15:0] MEM_Y_ADDR_O,
  input  wire [15:0] MEM_X_RDATA_I,
  input  wire [15:0] MEM_Y_RDATA_I,
  input  wire        MEM_ACK_I,
  // Status word.
  output reg  [15:0] STATUS_O,
  // APB slave.
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg         PREADY_O,
  output reg  [31:0] PRDATA_O,
  output reg         PSLVERR_O
);

  // ========================================================================
  // States and instruction classes
  // ========================================================================
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_EXEC = 2'h2;

  localparam [1:0] OP_NONE = 2'h0;
  localparam [1:0] OP_SQA  = 2'h1;
  localparam [1:0] OP_SWAP = 2'h2;
  localparam [1:0] OP_SCAN = 2'h3;

  // ========================================================================
  // Functions
  // ========================================================================
  // Pointer step of a prefetch mode code; 4 is the W12 offset mode.
  function [15:0] step_of;
    input [2:0] code;
    begin
      case (code)
        3'h1:    step_of = 16'h0002;
        3'h2:    step_of = 16'h0004;
        3'h3:    step_of = 16'h0006;
        3'h5:    step_of = 16'hFFFA;
        3'h6:    step_of = 16'hFFFC;
        3'h7:    step_of = 16'hFFFE;
        default: step_of = 16'h0000;
      endcase
    end
  endfunction

  // Effective prefetch address: offset mode adds W12 without touching the pointer.
  function [15:0] pf_addr;
    input [15:0] ptr;
    input [15:0] offs;
    input [2:0]  code;
    begin
      if (code == 3'h4)
        pf_addr = ptr + offs;
      else
        pf_addr = ptr;
    end
  endfunction

  // First bit change below the sign; result {carry, position}.
  function [16:0] scan_word;
    input [15:0] w;
    integer      b;
    reg          found;
    reg   [15:0] pos;
    begin
      found = 1'b0;
      pos   = 16'hFFF1;
      for (b = 14; b >= 0; b = b - 1)
      begin
        if (!found && (w[b] != w[15]))
        begin
          found = 1'b1;
          pos   = 16'h0000 - (16'd14 - b[15:0]);
        end
      end
      scan_word = {~found, pos};
    end
  endfunction

  // Accumulator value lies outside the 32-bit range (guard bits in use).
  function guard_ovf;
    input [39:0] a;
    begin
      guard_ovf = ~((&a[39:31]) | ~(|a[39:31]));
    end
  endfunction

  // ========================================================================
  // State
  // ========================================================================
  reg [15:0] wreg [0:15];
  reg [39:0] acc_a_reg;
  reg [39:0] acc_b_reg;
  reg [15:0] status_reg;
  reg [1:0]  state_reg;
  reg [1:0]  op_reg;
  reg [23:0] insn_reg;
  reg [15:0] x_data_reg;
  reg [15:0] y_data_reg;
  reg        apb_hold_reg;
  integer    i;

  // ========================================================================
  // Decode of the incoming word
  // ========================================================================
  reg [1:0] dec_op;

  // Classify; anything not matching exactly is left to the main decoder.
  always @*
  begin
    dec_op = OP_NONE;
    if (INSN_I[`SQX_OP_HI] == `SQX_SQA_HI_VAL && INSN_I[19:18] == 2'h0 &&
        INSN_I[14] == `SQX_SQA_FIX_LO && INSN_I[11:10] == 2'h0 &&
        INSN_I[1:0] == `SQX_SQA_TAIL_VAL)
      dec_op = OP_SQA;
    else if (INSN_I[23:12] == `SQX_SWAP_HI_VAL && !INSN_I[11] && INSN_I[6:4] == 3'h0)
      dec_op = OP_SWAP;
    else if (INSN_I[23:12] == `SQX_SCAN_HI_VAL && !INSN_I[11] &&
             INSN_I[6:4] <= `SQX_SCAN_MODE_MAX)
      dec_op = OP_SCAN;
  end

  // Prefetch and scan addresses for the incoming word.
  wire [3:0]  in_xptr  = `SQX_XPTR_BASE | {3'h0, INSN_I[9]};
  wire [3:0]  in_yptr  = `SQX_YPTR_BASE | {3'h0, INSN_I[5]};
  wire [15:0] in_xaddr = pf_addr(wreg[in_xptr], wreg[`SQX_OFFSET_REG], INSN_I[8:6]);
  wire [15:0] in_yaddr = pf_addr(wreg[in_yptr], wreg[`SQX_OFFSET_REG], INSN_I[4:2]);
  wire [15:0] in_sptr  = wreg[INSN_I[3:0]];
  wire        in_pre   = INSN_I[6];  // Modes 4 and 5 step before the access.
  wire [15:0] in_saddr = !in_pre ? in_sptr :
                         (INSN_I[4] ? in_sptr - `SQX_WORD_STEP : in_sptr + `SQX_WORD_STEP);

  // ========================================================================
  // Execute-cycle datapath
  // ========================================================================
  wire [3:0]  ex_sq    = `SQX_SQ_BASE | {2'h0, insn_reg[17:16]};
  wire [3:0]  ex_xd    = `SQX_SQ_BASE | {2'h0, insn_reg[13:12]};
  wire [3:0]  ex_xptr  = `SQX_XPTR_BASE | {3'h0, insn_reg[9]};
  wire [3:0]  ex_yptr  = `SQX_YPTR_BASE | {3'h0, insn_reg[5]};
  wire        ex_acc_b = insn_reg[15];
  wire [31:0] ex_sq_p  = $signed(wreg[ex_sq]) * $signed(wreg[ex_sq]);
  wire [39:0] ex_sq_x  = {{8{ex_sq_p[31]}}, ex_sq_p};
  wire [39:0] ex_acc   = ex_acc_b ? acc_b_reg : acc_a_reg;
  wire [39:0] ex_sum   = ex_acc + ex_sq_x;
  wire        ex_sat   = (ex_acc[39] == ex_sq_x[39]) && (ex_sum[39] != ex_acc[39]);
  wire [15:0] ex_diff  = x_data_reg - y_data_reg;
  wire [3:0]  ex_d     = insn_reg[10:7];
  wire [3:0]  ex_s     = insn_reg[3:0];
  wire [2:0]  ex_p     = insn_reg[6:4];
  wire [15:0] ex_src   = (ex_p == 3'h0) ? wreg[ex_s] : x_data_reg;
  wire [16:0] ex_scan  = scan_word(ex_src);
  wire [15:0] ex_sstep = (ex_p == 3'h3 || ex_p == 3'h5) ? (16'h0000 - `SQX_WORD_STEP) : `SQX_WORD_STEP;

  // Status after a square-accumulate: only the six accumulator flags move.
  reg [15:0] sqa_status;
  always @*
  begin
    sqa_status = status_reg;
    if (ex_acc_b)
    begin
      sqa_status[`SQX_STAT_B_OVF] = guard_ovf(ex_sum);
      sqa_status[`SQX_STAT_B_SAT] = status_reg[`SQX_STAT_B_SAT] | ex_sat;
    end
    else
    begin
      sqa_status[`SQX_STAT_A_OVF] = guard_ovf(ex_sum);
      sqa_status[`SQX_STAT_A_SAT] = status_reg[`SQX_STAT_A_SAT] | ex_sat;
    end
    sqa_status[`SQX_STAT_ANY_OVF] = sqa_status[`SQX_STAT_A_OVF] | sqa_status[`SQX_STAT_B_OVF];
    sqa_status[`SQX_STAT_ANY_SAT] = sqa_status[`SQX_STAT_A_SAT] | sqa_status[`SQX_STAT_B_SAT];
  end

  // ========================================================================
  // APB decode
  // ========================================================================
  wire [5:0] apb_idx  = PADDR_I[7:2];
  wire       apb_hit  = (PADDR_I[1:0] == 2'h0) && (apb_idx <= `SQX_IDX_STATUS);
  // Registers are only reached while no instruction is in flight, so the
  // register file never sees two writers on one edge.
  wire       apb_go   = PSEL_I && PENABLE_I && !apb_hold_reg && (state_reg == ST_IDLE) && !INSN_VALID_I;
  wire       apb_done = PSEL_I && PENABLE_I && apb_hold_reg;
  wire       apb_wr   = apb_done && PWRITE_I && !PSLVERR_O;

  reg [31:0] apb_rdata;
  always @*
  begin
    apb_rdata = 32'h0000_0000;
    if (apb_idx <= `SQX_IDX_WREG_LAST)
      apb_rdata = {16'h0000, wreg[apb_idx[3:0]]};
    else
    begin
      case (apb_idx)
        `SQX_IDX_ACC_A_LO: apb_rdata = acc_a_reg[31:0];
        `SQX_IDX_ACC_A_HI: apb_rdata = {24'h00_0000, acc_a_reg[39:32]};
        `SQX_IDX_ACC_B_LO: apb_rdata = acc_b_reg[31:0];
        `SQX_IDX_ACC_B_HI: apb_rdata = {24'h00_0000, acc_b_reg[39:32]};
        `SQX_IDX_STATUS:   apb_rdata = {16'h0000, status_reg};
        default:           apb_rdata = 32'h0000_0000;
      endcase
    end
  end

  // APB answer: one wait state when the sequencer is idle and no instruction is valid, then pready with registered data and error.
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      apb_hold_reg <= 1'b0;
      PREADY_O     <= 1'b0;
      PRDATA_O     <= 32'h0000_0000;
      PSLVERR_O    <= 1'b0;
    end
    else if (apb_go)
    begin
      apb_hold_reg <= 1'b1;
      PREADY_O     <= 1'b1;
      PRDATA_O     <= (apb_hit && !PWRITE_I) ? apb_rdata : 32'h0000_0000;
      PSLVERR_O    <= !apb_hit;
    end
    else
    begin
      apb_hold_reg <= 1'b0;
      PREADY_O     <= 1'b0;
      PSLVERR_O    <= 1'b0;
    end
  end

  // ========================================================================
  // Sequencer and prefetch requests
  // ========================================================================
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      state_reg    <= ST_IDLE;
      op_reg       <= OP_NONE;
      insn_reg     <= 24'h00_0000;
      x_data_reg   <= 16'h0000;
      y_data_reg   <= 16'h0000;
      BUSY_O       <= 1'b0;
      EXEC_DONE_O  <= 1'b0;
      PASS_O       <= 1'b0;
      MEM_X_REQ_O  <= 1'b0;
      MEM_Y_REQ_O  <= 1'b0;
      MEM_X_ADDR_O <= 16'h0000;
      MEM_Y_ADDR_O <= 16'h0000;
    end
    else
    begin
      EXEC_DONE_O <= 1'b0;
      PASS_O      <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (INSN_VALID_I)
          begin
            insn_reg <= INSN_I;
            op_reg   <= dec_op;
            if (dec_op == OP_NONE)
              PASS_O <= 1'b1;
            else if (dec_op == OP_SQA)
            begin
              // Both operands are fetched together.
              MEM_X_REQ_O  <= 1'b1;
              MEM_Y_REQ_O  <= 1'b1;
              MEM_X_ADDR_O <= in_xaddr;
              MEM_Y_ADDR_O <= in_yaddr;
              state_reg    <= ST_WAIT;
              BUSY_O       <= 1'b1;
            end
            else if (dec_op == OP_SCAN && INSN_I[6:4] != 3'h0)
            begin
              MEM_X_REQ_O  <= 1'b1;
              MEM_X_ADDR_O <= in_saddr;
              state_reg    <= ST_WAIT;
              BUSY_O       <= 1'b1;
            end
            else
            begin
              state_reg <= ST_EXEC;
              BUSY_O    <= 1'b1;
            end
          end
        end
        ST_WAIT:
        begin
          // A slow source (peripheral register) simply holds off the ack.
          if (MEM_ACK_I)
          begin
            x_data_reg  <= MEM_X_RDATA_I;
            y_data_reg  <= MEM_Y_RDATA_I;
            MEM_X_REQ_O <= 1'b0;
            MEM_Y_REQ_O <= 1'b0;
            state_reg   <= ST_EXEC;
          end
        end
        ST_EXEC:
        begin
          state_reg   <= ST_IDLE;
          BUSY_O      <= 1'b0;
          EXEC_DONE_O <= 1'b1;
        end
        default:
        begin
          state_reg   <= ST_IDLE;
          BUSY_O      <= 1'b0;
          MEM_X_REQ_O <= 1'b0;
          MEM_Y_REQ_O <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Register file, accumulators and status word
  // ========================================================================
  // Writes in program order of one instruction: later statements win, so a
  // scan destination that is also its pointer ends up with the result.
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
    begin
      for (i = 0; i < 16; i = i + 1)
        wreg[i] <= `SQX_WREG_RESET;
      acc_a_reg  <= `SQX_ACC_RESET;
      acc_b_reg  <= `SQX_ACC_RESET;
      status_reg <= `SQX_STAT_RESET;
    end
    else if (state_reg == ST_EXEC)
    begin
      case (op_reg)
        OP_SQA:
        begin
          if (ex_acc_b)
            acc_b_reg <= ex_sum;
          else
            acc_a_reg <= ex_sum;
          status_reg    <= sqa_status;
          wreg[ex_xptr] <= wreg[ex_xptr] + step_of(insn_reg[8:6]);
          wreg[ex_yptr] <= wreg[ex_yptr] + step_of(insn_reg[4:2]);
          wreg[ex_xd]   <= ex_diff;
        end
        OP_SWAP:
        begin
          wreg[ex_d] <= wreg[ex_s];
          wreg[ex_s] <= wreg[ex_d];
        end
        OP_SCAN:
        begin
          if (ex_p >= 3'h2)
            wreg[ex_s] <= wreg[ex_s] + ex_sstep;
          wreg[ex_d] <= ex_scan[15:0];
          status_reg[`SQX_STAT_CARRY] <= ex_scan[16];
        end
        default:
        begin
          status_reg <= status_reg;
        end
      endcase
    end
    else if (apb_wr)
    begin
      if (apb_idx <= `SQX_IDX_WREG_LAST)
        wreg[apb_idx[3:0]] <= PWDATA_I[15:0];
      else
      begin
        case (apb_idx)
          `SQX_IDX_ACC_A_LO: acc_a_reg[31:0]  <= PWDATA_I;
          `SQX_IDX_ACC_A_HI: acc_a_reg[39:32] <= PWDATA_I[7:0];
          `SQX_IDX_ACC_B_LO: acc_b_reg[31:0]  <= PWDATA_I;
          `SQX_IDX_ACC_B_HI: acc_b_reg[39:32] <= PWDATA_I[7:0];
          `SQX_IDX_STATUS:   status_reg       <= PWDATA_I[15:0];
          default:           status_reg       <= status_reg;
        endcase
      end
    end
  end

  // Status word mirrored to a port for the rest of the core.
  always @(posedge CLK_I)
  begin
    if (!NRST_I)
      STATUS_O <= `SQX_STAT_RESET;
    else
      STATUS_O <= status_reg;
  end

endmodule // sqx_exec

// ==== tb/sqx_mem_model.sv ====
`timescale 1ns/100ps

// ====================
// Prefetch memory model
// ====================
module sqx_mem_model
(
  // Clock and latency.
  input  wire        clk_i,
  input  wire [1:0]  lat_i,
  // Requests.
  input  wire        x_req_i,
  input  wire [15:0] x_addr_i,
  input  wire [15:0] y_addr_i,
  // Answer.
  output logic       ack_o,
  output logic [15:0] x_data_o,
  output logic [15:0] y_data_o
);
  logic [1:0] cnt_reg = 2'h0;

  initial
  begin
    ack_o = 1'b0;
    x_data_o = 16'h0000;
    y_data_o = 16'h0000;
  end

  // One ack answers both words; data is inverted afterwards so stale words never look valid.
  always @(posedge clk_i)
  begin
    if (ack_o)
    begin
      ack_o <= 1'b0;
      cnt_reg <= 2'h0;
      x_data_o <= ~x_data_o;
      y_data_o <= ~y_data_o;
    end
    else if (x_req_i && cnt_reg == lat_i)
    begin
      ack_o <= 1'b1;
      x_data_o <= {x_addr_i[7:0], x_addr_i[15:8]} ^ 16'h5A3C;
      y_data_o <= {y_addr_i[7:0], y_addr_i[15:8]} ^ 16'hC3A5;
    end
    else if (x_req_i)
      cnt_reg <= cnt_reg + 2'h1;
  end
endmodule // sqx_mem_model

// ==== tb/sqx_exec_asserts.sv ====
`timescale 1ns/100ps
`include "sqx_map.vh"

// ====================
// Port checker
// ====================
module sqx_exec_asserts
(
  // Clock and reset.
  input wire        CLK_I,
  input wire        NRST_I,
  // Instruction port.
  input wire [23:0] INSN_I,
  input wire        INSN_VALID_I,
  input wire        BUSY_O,
  input wire        EXEC_DONE_O,
  input wire        PASS_O,
  // Prefetch port.
  input wire        MEM_X_REQ_O,
  input wire [15:0] MEM_X_ADDR_O,
  input wire        MEM_Y_REQ_O,
  input wire        MEM_ACK_I,
  // APB.
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire [7:0]  PADDR_I,
  input wire        PREADY_O,
  input wire        PSLVERR_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  // Decode of the accepted word.
  wire take = INSN_VALID_I && !BUSY_O;
  wire hi_ok = !INSN_I[11] && INSN_I[6:4] == 3'h0;
  wire sqa = INSN_I[23:18] == 6'h3C && INSN_I[14] && INSN_I[11:10] == 2'h0 && INSN_I[1:0] == 2'h2;

  AST_PASS_PULSE: assert property (PASS_O |=> !PASS_O) else $error("pass pulse too long");
  AST_DONE_IDLE: assert property (EXEC_DONE_O |-> !BUSY_O ##1 !EXEC_DONE_O) else $error("done misbehaves");
  AST_SWAP_ONE: assert property (take && hi_ok && INSN_I[23:12] == `SQX_SWAP_HI_VAL
    |=> BUSY_O ##1 EXEC_DONE_O) else $error("swap not single cycle");
  AST_SCAN_ONE: assert property (take && hi_ok && INSN_I[23:12] == `SQX_SCAN_HI_VAL
    |=> !MEM_X_REQ_O ##1 EXEC_DONE_O) else $error("direct scan late");
  AST_SQA_REQ: assert property (take && sqa |=> MEM_X_REQ_O && MEM_Y_REQ_O && BUSY_O) else $error("no prefetch");
  AST_MEM_HOLD: assert property (MEM_X_REQ_O && !MEM_ACK_I |=> MEM_X_REQ_O && $stable(MEM_X_ADDR_O))
    else $error("prefetch request dropped");
  AST_MEM_DONE: assert property (MEM_X_REQ_O && MEM_ACK_I |=> !MEM_X_REQ_O && !MEM_Y_REQ_O ##1 EXEC_DONE_O)
    else $error("no finish after ack");
  AST_Y_WITH_X: assert property (MEM_Y_REQ_O |-> MEM_X_REQ_O) else $error("lone Y request");
  AST_APB_WAIT: assert property (PREADY_O |-> PSEL_I && PENABLE_I && $past(PENABLE_I) ##1 !PREADY_O)
    else $error("apb ready misplaced");
  AST_APB_ERR: assert property (PREADY_O && (PADDR_I > 8'h50 || PADDR_I[1:0] != 2'h0) |-> PSLVERR_O)
    else $error("bad address accepted");
endmodule // sqx_exec_asserts

bind sqx_exec sqx_exec_asserts u_chk (.CLK_I(CLK_I), .NRST_I(NRST_I), .INSN_I(INSN_I),
  .INSN_VALID_I(INSN_VALID_I), .BUSY_O(BUSY_O), .EXEC_DONE_O(EXEC_DONE_O), .PASS_O(PASS_O),
  .MEM_X_REQ_O(MEM_X_REQ_O), .MEM_X_ADDR_O(MEM_X_ADDR_O), .MEM_Y_REQ_O(MEM_Y_REQ_O), .MEM_ACK_I(MEM_ACK_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O));

// ==== tb/sqx_exec_test.sv ====
`timescale 1ns/100ps
`include "sqx_map.vh"

// ====================
// Testbench
// ====================
module sqx_exec_test;
  logic        clk = 1'b0, nrst = 1'b0, valid = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [23:0] insn = 24'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [1:0]  lat = 2'h0;
  wire         busy, done, pass, xreq, yreq, ack, pready, pslverr;
  wire  [15:0] xaddr, yaddr, xdat, ydat, status;
  wire  [31:0] prdata;
  logic [15:0] w [16];
  logic [39:0] a [2];
  logic [15:0] stat;
  logic [15:0] qs [$];
  logic        fin_q = 1'b0;
  logic [31:0] rnd = 32'hFFAB6073;
  logic [32:0] qa [$];
  logic        qi [$];
  int          miscompares = 0;
  int          n_tests = 0;

  sqx_exec dut (.CLK_I(clk), .NRST_I(nrst), .INSN_I(insn), .INSN_VALID_I(valid), .BUSY_O(busy),
    .EXEC_DONE_O(done), .PASS_O(pass), .MEM_X_REQ_O(xreq), .MEM_X_ADDR_O(xaddr), .MEM_Y_REQ_O(yreq),
    .MEM_Y_ADDR_O(yaddr), .MEM_X_RDATA_I(xdat), .MEM_Y_RDATA_I(ydat), .MEM_ACK_I(ack), .STATUS_O(status),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr));
  sqx_mem_model u_mem (.clk_i(clk), .lat_i(lat), .x_req_i(xreq), .x_addr_i(xaddr), .y_addr_i(yaddr),
    .ack_o(ack), .x_data_o(xdat), .y_data_o(ydat));

  // Clock of 100 ns.
  initial
  begin
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] nxt();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction
  function automatic logic [15:0] fx(input logic [15:0] v, input logic [15:0] k);
    return {v[7:0], v[15:8]} ^ k;
  endfunction
  // Scan result: position 0 just below the sign, -15 when every bit matches it.
  function automatic logic [15:0] scan(input logic [15:0] v);
    for (int k = 14; k >= 0; k--)
      if (v[k] !== v[15])
        return 16'(k - 14);
    return 16'hFFF1;
  endfunction

  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, held until ready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic er);
    qa.push_back({er, e});
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic wrw(input int i, input logic [15:0] v);
    w[i] = v;
    apb(1'b1, 8'(4 * i), {16'h0, v});
  endtask
  task automatic chk_all();
    for (int i = 0; i < 16; i++)
      rd(8'(4 * i), {16'h0, w[i]}, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      rd(8'(64 + 8 * k), a[k][31:0], 1'b0);
      rd(8'(68 + 8 * k), {24'h0, a[k][39:32]}, 1'b0);
    end
    rd(8'h50, {16'h0, stat}, 1'b0);
  endtask

  // One instruction, valid for a single cycle, then a bounded wait for its answer.
  task automatic exe(input logic [23:0] op, input logic p);
    int n;
    n = 0;
    qi.push_back(p);
    qs.push_back(stat);
    @(posedge clk);
    insn <= op;
    valid <= 1'b1;
    @(posedge clk) valid <= 1'b0;
    while (done !== 1'b1 && pass !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 40)
    begin
      miscompares++;
      $display("[FAIL] finish expected 1 seen 0");
    end
  endtask

  task automatic pf(input logic [3:0] c, input int b, output logic [15:0] ad);
    int r;
    r = b + c[3];
    ad = (c[2:0] == 3'h4) ? w[r] + w[12] : w[r];
    if (c[2:0] inside {[1:3]})
      w[r] = w[r] + 16'(2 * c[2:0]);
    if (c[2:0] > 3'h4)
      w[r] = w[r] - 16'(16 - 2 * c[2:0]);
  endtask
  task automatic sqa(input logic [23:0] op);
    logic [15:0] ax, ay, m;
    logic signed [31:0] sq;
    logic [39:0] s;
    int k;
    k = op[15];
    m = w[4 + op[17:16]];
    sq = $signed(m) * $signed(m);
    pf(op[9:6], 8, ax);
    pf(op[5:2], 10, ay);
    s = a[k] + {8'h0, sq};
    if (!a[k][39] && s[39])
      stat[13 - k] = 1'b1;
    a[k] = s;
    w[4 + op[13:12]] = fx(ax, 16'h5A3C) - fx(ay, 16'hC3A5);
    // Only the target accumulator's overflow flag is recomputed; the other keeps its value.
    stat[15 - k] = a[k][39:31] != 9'h000 && a[k][39:31] != 9'h1FF;
    stat[11] = stat[15] | stat[14];
    stat[10] = stat[13] | stat[12];
    exe(op, 1'b0);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Results are matched in order against the notes left by the drivers.
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp("apb read", qa.size() ? qa.pop_front() : 33'hX, {pslverr, prdata});
    if (done === 1'b1 || pass === 1'b1)
      cmp("pass flag", {32'h0, qi.size() ? qi.pop_front() : 1'bX}, {32'h0, pass});
    // The status port lags the internal word by one cycle, so it is looked at one edge after the finish.
    if (fin_q)
      cmp("status word", {17'h0, qs.size() ? qs.pop_front() : 16'hXXXX}, {17'h0, status});
    fin_q <= (done === 1'b1 || pass === 1'b1);
  end

  // Watchdog sized well above the few thousand cycles the run needs.
  initial
  begin
    repeat (30000) @(posedge clk);
    miscompares++;
    summarize();
  end

  initial
  begin
    logic [3:0] d, s;
    logic [15:0] t, v, ea;
    logic [15:0] vals [9] = '{16'h55FF, 16'hFFFF, 16'hFF0A, 16'h0000, 16'h0001, 16'h8000, 16'hC000,
      16'h4000, 16'hFFFE};
    logic [23:0] bad [5] = '{24'hFD0812, 24'hFD0052, 24'hDF0061, 24'hDF0073, 24'h0A1234};
    foreach (w[i]) w[i] = 16'h0;
    a[0] = 40'h0;
    a[1] = 40'h0;
    stat = 16'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    chk_all();
    rd(8'h54, 32'h0, 1'b1);
    rd(8'h06, 32'h0, 1'b1);
    for (int i = 0; i < 16; i++)
      wrw(i, 16'(nxt()));
    a[0] = 40'h7F_FFFF_0000;
    a[1] = {nxt(), 8'h00};
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, 8'(64 + 8 * k), a[k][31:0]);
      apb(1'b1, 8'(68 + 8 * k), {24'h0, a[k][39:32]});
    end
    stat = 16'h0001;
    apb(1'b1, 8'h50, 32'h1);
    chk_all();
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      t = 16'(nxt());
      d = t[3:0];
      s = (i == 0) ? d : t[7:4];
      t = w[d];
      w[d] = w[s];
      w[s] = t;
      exe({`SQX_SWAP_HI_VAL, 1'b0, d, 3'h0, s}, 1'b0);
      chk_all();
    end
    foreach (bad[i])
      exe(bad[i], 1'b1);
    chk_all();
    $display("test swap done");
    for (int i = 0; i < 13; i++)
    begin
      t = 16'(nxt());
      v = (i < 9) ? vals[i] : 16'(nxt());
      wrw(t[3:0], v);
      w[t[7:4]] = scan(v);
      stat[0] = (w[t[7:4]] === 16'hFFF1);
      exe({`SQX_SCAN_HI_VAL, 1'b0, t[7:4], 3'h0, t[3:0]}, 1'b0);
      chk_all();
    end
    for (int p = 1; p < 6; p++)
    begin
      t = 16'(nxt());
      s = t[3:0];
      d = t[7:4];
      lat <= t[9:8];
      ea = (p > 3) ? w[s] + ((p == 4) ? 16'h0002 : 16'hFFFE) : w[s];
      if (p != 1)
        w[s] = (p == 2 || p == 4) ? w[s] + 16'h0002 : w[s] - 16'h0002;
      w[d] = scan(fx(ea, 16'h5A3C));
      stat[0] = (w[d] === 16'hFFF1);
      exe({`SQX_SCAN_HI_VAL, 1'b0, d, 3'(p), s}, 1'b0);
      chk_all();
    end
    $display("test scan done");
    for (int i = 0; i < 8; i++)
    begin
      t = 16'(nxt());
      lat <= t[15:14];
      sqa({4'hF, 2'h0, t[1:0], i[0], 1'b1, t[4:3], 2'h0, t[5], 3'(i), t[6], 3'(7 - i), 2'h2});
      chk_all();
    end
    $display("test square accumulate done");
    summarize();
  end
endmodule // sqx_exec_test
